// >>> hdl/usb_port_power_regs.vh
`ifndef USB_PORT_POWER_REGS_VH
`define USB_PORT_POWER_REGS_VH

// ****************************************
// Power state codes
// ****************************************
`define ST_OFF     3'h0
`define ST_SLEEP   3'h1
`define ST_DETECT  3'h2
`define ST_BYPOFF  3'h3
`define ST_DISCH   3'h4
`define ST_ACTIVE  3'h5
`define ST_ERROR   3'h6

// ****************************************
// Register offsets and fields
// ****************************************
`define CTRL_OFS      8'h00
`define STAT_OFS      8'h04
`define CTRL_ALERT_EN 0
`define CTRL_ERR_CLR  1
`define CTRL_HS_DET   2
`define CTRL_RESET    1'h1

// ****************************************
// Mode codes on {emulation, b, a}
// ****************************************
`define MODE_PASSTHRU 3'h1
`define MODE_CYCLE    3'h7

// ****************************************
// Timing
// ****************************************
`define CLK_NS         25
`define T_DISCHARGE_NS 2000
`define DISCHARGE_CYC  ((`T_DISCHARGE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WAKE_IDLE_NS 1000000
`define WAKE_IDLE_CYC  (`T_WAKE_IDLE_NS / `CLK_NS)
`define T_PROFILE_NS   2000000
`define PROFILE_CYC    (`T_PROFILE_NS / `CLK_NS)

`endif

// >>> hdl/usb_port_power_state_control.v
`include "usb_port_power_regs.vh"

module usb_port_power_state_control
#(
  parameter DISCHARGE_CYC = `DISCHARGE_CYC,
  parameter WAKE_IDLE_CYC = `WAKE_IDLE_CYC,
  parameter PROFILE_CYC   = `PROFILE_CYC
)
(
  // Clock and reset
  input  wire        mclk_i,
  input  wire        reset_i,
  // Supply comparators and control pins
  input  wire        core_supply_threshold_i,
  input  wire        source_undervoltage_threshold_i,
  input  wire        port_power_request_i,
  input  wire        attach_detect_select_i,
  input  wire        mode_select_a_i,
  input  wire        mode_select_b_i,
  input  wire        emulation_enable_i,
  // Port events from analog front end
  input  wire        attach_event_i,
  input  wire        removal_event_i,
  input  wire        fault_i,
  // SMBus engine byte events
  input  wire        smb_byte_read_i,
  input  wire        smb_byte_write_i,
  input  wire        smb_stop_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Switch and feature enables
  output reg         port_switch_o,
  output reg         bypass_switch_o,
  output reg         hs_switch_o,
  output reg         discharge_o,
  output reg         attach_detect_en_o,
  output reg         removal_detect_en_o,
  output reg         current_monitor_en_o,
  output reg         emulation_active_o,
  output reg  [1:0]  profile_o,
  // Status pins
  output reg         alert_n_o,
  output reg         attach_flag_n_o,
  output reg  [2:0]  power_state_o,
  // SMBus control
  output reg         smb_respond_o,
  output reg         smb_single_byte_o,
  output reg         smb_read_zero_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg  [9:0]  pin_meta_q;
  reg  [9:0]  pin_sync_q;

  // Two flops for every pin
  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pin_meta_q <= 10'h000;
      pin_sync_q <= 10'h000;
    end
    else
    begin
      pin_meta_q <= {fault_i, removal_event_i, attach_event_i,
                     emulation_enable_i, mode_select_b_i, mode_select_a_i,
                     attach_detect_select_i, port_power_request_i,
                     source_undervoltage_threshold_i, core_supply_threshold_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire        core_ok  = pin_sync_q[0];
  wire        vs_ok    = pin_sync_q[1];
  wire        pwr_req  = pin_sync_q[2];
  wire        sel      = pin_sync_q[3];
  wire [2:0]  mode     = pin_sync_q[6:4];
  wire        attach   = pin_sync_q[7];
  wire        removal  = pin_sync_q[8];
  wire        fault    = pin_sync_q[9];
  wire        mode_z   = (mode == 3'h0);
  wire        pass_thr = (mode == `MODE_PASSTHRU);
  // Core supply loss clears all digital state but the synchronisers and the Wishbone slave
  wire        clr      = reset_i | ~core_ok;

  // ****************************************
  // State registers
  // ****************************************
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         attached_q;
  reg         attached_d;
  reg         awake_q;
  reg         pwr_prev_q;
  reg         err_clr_q;
  reg         alert_en_q;
  reg         hs_det_q;
  reg         cycle_hold_q;
  reg  [1:0]  profile_q;
  reg  [23:0] tmr_q;
  reg  [23:0] idle_q;
  reg  [2:0]  dec;
  reg         dec_ok;
  reg  [2:0]  tgt;

  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        ctrl_wr  = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CTRL_OFS);
  wire        tmr_end  = (tmr_q == DISCHARGE_CYC - 1);
  wire        in_sleep = (state_q == `ST_SLEEP);
  wire        cyc_mode = (state_q == `ST_ACTIVE) & ~sel & (mode == `MODE_CYCLE);
  // Greater-or-equal so a timer already past the step point cannot stall cycling
  wire        prof_step = cyc_mode & (tmr_q >= PROFILE_CYC - 1);

  // Decode the control combination into a target state
  always @*
  begin
    dec    = state_q;
    dec_ok = 1'b1;
    if (~sel & ((~pwr_req & ~pass_thr) | (pwr_req & mode_z)))
      dec = `ST_SLEEP;
    else if (sel & (~pwr_req | (~vs_ok & ~mode_z)))
      dec = `ST_DETECT;
    else if (~sel & pwr_req & vs_ok & ~mode_z)
      dec = `ST_ACTIVE;
    else if (sel & pwr_req & vs_ok & ~mode_z)
      dec = attached_q ? `ST_ACTIVE : `ST_DETECT;
    else
      dec_ok = 1'b0;
  end

  // Next state
  always @*
  begin
    tgt     = dec_ok ? dec : state_q;
    state_d = state_q;
    case (state_q)
      `ST_OFF:
        state_d = dec_ok ? dec : `ST_SLEEP;
      `ST_ERROR:
        if (~fault & (err_clr_q | (pwr_req ^ pwr_prev_q)))
          state_d = dec_ok ? dec : `ST_SLEEP;
      `ST_DETECT:
        state_d = (tgt == `ST_ACTIVE) ? `ST_BYPOFF : tgt;
      `ST_BYPOFF:
        state_d = (tgt == `ST_ACTIVE | ~dec_ok) ? `ST_DISCH : tgt;
      `ST_DISCH:
        if (tgt != `ST_ACTIVE & dec_ok)
          state_d = tgt;
        else if (tmr_end)
          state_d = `ST_ACTIVE;
      `ST_SLEEP,
      `ST_ACTIVE:
        state_d = tgt;
      default:
        state_d = `ST_OFF;
    endcase
    if (fault & state_q != `ST_OFF)
      state_d = `ST_ERROR;
  end

  // Attach memory
  always @*
  begin
    attached_d = attached_q;
    if (state_q == `ST_DETECT & attach)
      attached_d = 1'b1;
    if ((state_q == `ST_ACTIVE | state_q == `ST_ERROR) & sel & removal)
      attached_d = 1'b0;
    if (~sel | state_d == `ST_SLEEP)
      attached_d = 1'b0;
  end

  // ****************************************
  // Sequential core
  // ****************************************
  // State, timers and control bits
  always @(posedge mclk_i)
  begin
    if (clr)
    begin
      state_q      <= `ST_OFF;
      attached_q   <= 1'b0;
      pwr_prev_q   <= 1'b0;
      err_clr_q    <= 1'b0;
      alert_en_q   <= `CTRL_RESET;
      hs_det_q     <= 1'b0;
      tmr_q        <= 24'h000000;
      profile_q    <= 2'h0;
      cycle_hold_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      attached_q <= attached_d;
      pwr_prev_q <= pwr_req;
      if (ctrl_wr)
      begin
        alert_en_q <= wb_dat_i[`CTRL_ALERT_EN];
        hs_det_q   <= wb_dat_i[`CTRL_HS_DET];
      end
      // Clear request waits for the fault to go
      if (ctrl_wr & wb_dat_i[`CTRL_ERR_CLR])
        err_clr_q <= 1'b1;
      else if (state_q != `ST_ERROR)
        err_clr_q <= 1'b0;
      // Timer restarts on each state change and each profile step
      if (state_d != state_q | prof_step)
        tmr_q <= 24'h000000;
      else
        tmr_q <= tmr_q + 24'h000001;
      // Profile cycling until a device is seen
      if (~cyc_mode)
        cycle_hold_q <= 1'b0;
      else if (attach)
        cycle_hold_q <= 1'b1;
      if (prof_step & ~cycle_hold_q)
        profile_q <= profile_q + 2'h1;
    end
  end

  // ****************************************
  // SMBus wake in Sleep
  // ****************************************
  // First read wakes, idle or stop returns to low power
  always @(posedge mclk_i)
  begin
    if (clr)
    begin
      awake_q         <= 1'b0;
      idle_q          <= 24'h000000;
      smb_read_zero_o <= 1'b0;
    end
    else
    begin
      smb_read_zero_o <= in_sleep & ~awake_q & smb_byte_read_i;
      if (~in_sleep)
        awake_q <= 1'b0;
      else if (~awake_q & smb_byte_read_i)
        awake_q <= 1'b1;
      else if (awake_q & (smb_stop_i | idle_q == WAKE_IDLE_CYC - 1))
        awake_q <= 1'b0;
      if (~awake_q | smb_byte_read_i | smb_byte_write_i)
        idle_q <= 24'h000000;
      else
        idle_q <= idle_q + 24'h000001;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Switch and feature enables follow the state
  always @(posedge mclk_i)
  begin
    if (clr)
    begin
      port_switch_o        <= 1'b0;
      bypass_switch_o      <= 1'b0;
      hs_switch_o          <= 1'b0;
      discharge_o          <= 1'b0;
      attach_detect_en_o   <= 1'b0;
      removal_detect_en_o  <= 1'b0;
      current_monitor_en_o <= 1'b0;
      emulation_active_o   <= 1'b0;
      profile_o            <= 2'h0;
      power_state_o        <= `ST_OFF;
      smb_respond_o        <= 1'b0;
      smb_single_byte_o    <= 1'b0;
    end
    else
    begin
      port_switch_o        <= (state_q == `ST_ACTIVE);
      bypass_switch_o      <= (state_q == `ST_DETECT);
      hs_switch_o          <= (state_q == `ST_ACTIVE & pass_thr) |
                              (state_q == `ST_DETECT & hs_det_q);
      discharge_o          <= (state_q == `ST_DISCH);
      attach_detect_en_o   <= (state_q == `ST_DETECT);
      removal_detect_en_o  <= sel & (state_q == `ST_ACTIVE |
                              state_q == `ST_BYPOFF | state_q == `ST_DISCH);
      current_monitor_en_o <= (state_q == `ST_ACTIVE);
      emulation_active_o   <= (state_q == `ST_ACTIVE) & ~pass_thr;
      profile_o            <= profile_q;
      power_state_o        <= state_q;
      smb_respond_o        <= (state_q != `ST_OFF);
      smb_single_byte_o    <= in_sleep;
    end
  end

  // Alert and attach flag pins
  always @(posedge mclk_i)
  begin
    if (clr)
    begin
      alert_n_o       <= 1'b1;
      attach_flag_n_o <= 1'b1;
    end
    else
    begin
      if (state_q == `ST_SLEEP)
        alert_n_o <= 1'b1;
      else if (state_q == `ST_ERROR & alert_en_q)
        alert_n_o <= 1'b0;
      else if (state_q != `ST_ERROR)
        alert_n_o <= 1'b1;
      attach_flag_n_o <= ~(attached_q & ~in_sleep);
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One wait state, unmapped reads return zero
  always @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req & ~wb_we_i & wb_adr_i == `CTRL_OFS)
        wb_dat_o <= {29'h0, hs_det_q, 1'b0, alert_en_q};
      else if (wb_req & ~wb_we_i & wb_adr_i == `STAT_OFS)
        wb_dat_o <= {24'h0, profile_q, fault, awake_q, attached_q, state_q};
    end
  end

endmodule

// >>> test/usb_port_power_state_control_sva.sv
module usb_port_power_state_control_sva
#(
  parameter DISCHARGE_CYC = 80
)
(
  // Clock, reset and inputs
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       core_supply_threshold_i,
  input wire logic       fault_i,
  input wire logic       smb_byte_read_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  // Watched outputs
  input wire logic       wb_ack_o,
  input wire logic       port_switch_o,
  input wire logic       bypass_switch_o,
  input wire logic       hs_switch_o,
  input wire logic       discharge_o,
  input wire logic       attach_detect_en_o,
  input wire logic       removal_detect_en_o,
  input wire logic       current_monitor_en_o,
  input wire logic       alert_n_o,
  input wire logic       attach_flag_n_o,
  input wire logic [2:0] power_state_o,
  input wire logic       smb_respond_o,
  input wire logic       smb_single_byte_o,
  input wire logic       smb_read_zero_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [15:0] dcnt_q;
  // Length of the discharge pulse so far
  always_ff @(posedge mclk_i)
    dcnt_q <= (reset_i || !discharge_o) ? 16'h0 : dcnt_q + 16'h1;
  sequence s_open;
    !port_switch_o && !bypass_switch_o && !hs_switch_o;
  endsequence
  sequence s_acked;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_off;
    !core_supply_threshold_i [*6] |-> (power_state_o == 3'h0 && !smb_respond_o) ##0 s_open;
  endproperty
  property p_sleep;
    power_state_o == 3'h1 |-> s_open ##0 (!attach_detect_en_o && !removal_detect_en_o
      && alert_n_o && attach_flag_n_o && smb_single_byte_o);
  endproperty
  property p_detect;
    power_state_o == 3'h2 |-> !port_switch_o && !current_monitor_en_o;
  endproperty
  property p_active;
    power_state_o == 3'h5 |-> port_switch_o && current_monitor_en_o && !bypass_switch_o;
  endproperty
  property p_error;
    power_state_o == 3'h6 |-> s_open;
  endproperty
  property p_order;
    $rose(discharge_o) |-> !bypass_switch_o && !attach_detect_en_o && !port_switch_o;
  endproperty
  property p_dlen;
    $fell(discharge_o) |-> dcnt_q == DISCHARGE_CYC && port_switch_o;
  endproperty
  property p_fault;
    (fault_i && core_supply_threshold_i) [*8] |-> power_state_o == 3'h6;
  endproperty
  property p_wake;
    smb_read_zero_o |-> smb_single_byte_o && ($past(smb_byte_read_i) || $past(smb_byte_read_i, 2));
  endproperty
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_acked;
  endproperty
  a_off: assert property (p_off) else $error("not off on low core supply");
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  a_detect: assert property (p_detect) else $error("detect outputs wrong");
  a_active: assert property (p_active) else $error("active outputs wrong");
  a_error: assert property (p_error) else $error("switch closed in error");
  a_order: assert property (p_order) else $error("discharge out of order");
  a_dlen: assert property (p_dlen) else $error("discharge length wrong");
  a_fault: assert property (p_fault) else $error("fault did not enter error");
  a_wake: assert property (p_wake) else $error("zero byte without read");
  a_ack: assert property (p_ack) else $error("bus ack wrong");
endmodule

// >>> test/host_pins_model.sv
module host_pins_model
(
  // Clock and wanted settings
  input  wire logic       mclk_i,
  input  wire logic [2:0] mode_want_i,
  input  wire logic       req_want_i,
  // Control pins of the device
  output logic      [2:0] mode_o = 3'h0,
  output logic            req_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Mode pins always settle a cycle before the request moves
  always @(posedge mclk_i)
    if (mode_o != mode_want_i)
      mode_o <= mode_want_i;
    else
      req_o <= req_want_i;
endmodule

// >>> test/usb_port_power_state_control_tb.sv
module usb_port_power_state_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0, reset_i = 1'b1, fault_i = 1'b0, req_w = 1'b0;
  logic        core_supply_threshold_i = 1'b0, source_undervoltage_threshold_i = 1'b0;
  logic        attach_detect_select_i = 1'b0, attach_event_i = 1'b0, removal_event_i = 1'b0;
  logic        smb_byte_read_i = 1'b0, smb_byte_write_i = 1'b0, smb_stop_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, rdat, wb_dat_o;
  logic [2:0]  mode_w = 3'h0, power_state_o;
  logic [1:0]  profile_o, prof;
  logic        port_power_request_i, mode_select_a_i, mode_select_b_i, emulation_enable_i;
  logic        wb_ack_o, port_switch_o, bypass_switch_o, hs_switch_o, discharge_o;
  logic        attach_detect_en_o, removal_detect_en_o, current_monitor_en_o;
  logic        emulation_active_o, alert_n_o, attach_flag_n_o, smb_respond_o;
  logic        smb_single_byte_o, smb_read_zero_o;
  int          fails = 0, checks = 0, zeros = 0;
  wire logic [7:0] outs = {port_switch_o, bypass_switch_o, hs_switch_o, attach_detect_en_o,
    removal_detect_en_o, current_monitor_en_o, alert_n_o, attach_flag_n_o};
  usb_port_power_state_control #(.DISCHARGE_CYC(4), .WAKE_IDLE_CYC(20), .PROFILE_CYC(10))
    i_dut (.mclk_i(mclk_i), .reset_i(reset_i),
      .core_supply_threshold_i(core_supply_threshold_i),
      .source_undervoltage_threshold_i(source_undervoltage_threshold_i),
      .port_power_request_i(port_power_request_i),
      .attach_detect_select_i(attach_detect_select_i),
      .mode_select_a_i(mode_select_a_i), .mode_select_b_i(mode_select_b_i),
      .emulation_enable_i(emulation_enable_i), .attach_event_i(attach_event_i),
      .removal_event_i(removal_event_i), .fault_i(fault_i),
      .smb_byte_read_i(smb_byte_read_i), .smb_byte_write_i(smb_byte_write_i),
      .smb_stop_i(smb_stop_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_switch_o(port_switch_o),
      .bypass_switch_o(bypass_switch_o), .hs_switch_o(hs_switch_o),
      .discharge_o(discharge_o), .attach_detect_en_o(attach_detect_en_o),
      .removal_detect_en_o(removal_detect_en_o),
      .current_monitor_en_o(current_monitor_en_o),
      .emulation_active_o(emulation_active_o), .profile_o(profile_o),
      .alert_n_o(alert_n_o), .attach_flag_n_o(attach_flag_n_o),
      .power_state_o(power_state_o), .smb_respond_o(smb_respond_o),
      .smb_single_byte_o(smb_single_byte_o), .smb_read_zero_o(smb_read_zero_o));
  host_pins_model i_host (.mclk_i(mclk_i), .mode_want_i(mode_w), .req_want_i(req_w),
    .mode_o({emulation_enable_i, mode_select_b_i, mode_select_a_i}),
    .req_o(port_power_request_i));
  // Clock and count of zero-byte pulses
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
    if (smb_read_zero_o === 1'b1)
      zeros++;
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // One classic bus cycle, waits for the ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // Waits for a state, then compares the masked outputs
  task automatic st(input logic [2:0] s, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    while (power_state_o !== s && n++ < 60)
      @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    chk("state", 32'(power_state_o), 32'(s));
    chk("outputs", 32'(outs & m), 32'(e));
  endtask
  // One-cycle pulse: 0 read byte, 1 stop, 2 attach, 3 removal
  task automatic pulse(input logic [1:0] k);
    smb_byte_read_i <= (k == 2'h0);
    smb_stop_i <= (k == 2'h1);
    attach_event_i <= (k == 2'h2);
    removal_event_i <= (k == 2'h3);
    @(posedge mclk_i);
    smb_byte_read_i <= 1'b0;
    smb_stop_i <= 1'b0;
    attach_event_i <= 1'b0;
    removal_event_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    st(3'h0, 8'hff, 8'h03);
    chk("respond", 32'(smb_respond_o), 32'h0);
    core_supply_threshold_i <= 1'b1;
    st(3'h1, 8'hff, 8'h03);
    chk("single", 32'(smb_single_byte_o), 32'h1);
    chk("respond", 32'(smb_respond_o), 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rdat, 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", rdat, 32'h0);
    pulse(2'h0);
    chk("zeros", 32'(zeros), 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk("awake", 32'(rdat[4]), 32'h1);
    pulse(2'h0);
    chk("zeros", 32'(zeros), 32'h1);
    pulse(2'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk("awake", 32'(rdat[4]), 32'h0);
    pulse(2'h0);
    repeat (25) @(posedge mclk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk("idle", 32'(rdat[4]), 32'h0);
    chk("zeros", 32'(zeros), 32'h2);
    mode_w <= 3'h1;
    req_w <= 1'b1;
    source_undervoltage_threshold_i <= 1'b1;
    st(3'h5, 8'hff, 8'ha7);
    chk("emulation", 32'(emulation_active_o), 32'h0);
    mode_w <= 3'h0;
    req_w <= 1'b0;
    st(3'h1, 8'hff, 8'h03);
    attach_detect_select_i <= 1'b1;
    st(3'h2, 8'hff, 8'h53);
    mode_w <= 3'h7;
    req_w <= 1'b1;
    repeat (10) @(posedge mclk_i);
    st(3'h2, 8'hff, 8'h53);
    pulse(2'h2);
    st(3'h5, 8'hff, 8'h8e);
    pulse(2'h3);
    st(3'h2, 8'hff, 8'h53);
    attach_detect_select_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    st(3'h5, 8'hff, 8'h87);
    chk("emulation", 32'(emulation_active_o), 32'h1);
    prof = profile_o;
    repeat (25) @(posedge mclk_i);
    chk("cycling", 32'(profile_o !== prof), 32'h1);
    fault_i <= 1'b1;
    st(3'h6, 8'he2, 8'h00);
    repeat (3) @(posedge mclk_i);
    fault_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    wb(1'b1, 8'h00, 32'h3);
    repeat (10) @(posedge mclk_i);
    chk("released", {power_state_o == 3'h6, alert_n_o}, 32'h1);
    core_supply_threshold_i <= 1'b0;
    st(3'h0, 8'hff, 8'h03);
    wrap_up();
  end
endmodule
bind usb_port_power_state_control usb_port_power_state_control_sva
  #(.DISCHARGE_CYC(DISCHARGE_CYC)) i_sva (.mclk_i(mclk_i), .reset_i(reset_i),
  .core_supply_threshold_i(core_supply_threshold_i), .fault_i(fault_i),
  .smb_byte_read_i(smb_byte_read_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .port_switch_o(port_switch_o), .bypass_switch_o(bypass_switch_o),
  .hs_switch_o(hs_switch_o), .discharge_o(discharge_o),
  .attach_detect_en_o(attach_detect_en_o), .removal_detect_en_o(removal_detect_en_o),
  .current_monitor_en_o(current_monitor_en_o), .alert_n_o(alert_n_o),
  .attach_flag_n_o(attach_flag_n_o), .power_state_o(power_state_o),
  .smb_respond_o(smb_respond_o), .smb_single_byte_o(smb_single_byte_o),
  .smb_read_zero_o(smb_read_zero_o));
